// ==== dv/i2c_master_model.sv ====
// two-wire bus master model: drives scl and its side of sda
// assumes the bench forms the wired sda with a pull-up
module i2c_master_model (
  input  wire logic i_core_clk,
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda_drv
);
  timeunit 1ns;
  timeprecision 1ps;
  // bus idle high at time zero
  initial begin
    o_scl     = 1'b1;
    o_sda_drv = 1'b1;
  end
  // ==================================================================
  // bus timing, quarter of the 80 ns scl period per step
  task automatic q(input int c);
    repeat (c) @(posedge i_core_clk);
    #1;
  endtask : q
  // sda set in low phase, held across scl high
  task automatic bit_io(input logic b, output logic s);
    o_sda_drv = b;
    q(5);
    o_scl = 1'b1;
    q(5);
    s = i_sda;
    q(5);
    o_scl = 1'b0;
    q(5);
  endtask : bit_io
  // start or repeated start
  task automatic start();
    o_sda_drv = 1'b1;
    q(5);
    o_scl = 1'b1;
    q(5);
    o_sda_drv = 1'b0;
    q(5);
    o_scl = 1'b0;
    q(5);
  endtask : start
  task automatic stop();
    o_sda_drv = 1'b0;
    q(5);
    o_scl = 1'b1;
    q(5);
    o_sda_drv = 1'b1;
    q(5);
  endtask : stop
  // msb first, ninth clock for ack unless held low
  task automatic wr_byte(input logic [7:0] b, input logic hold,
                         output logic ack);
    logic s;
    ack = 1'b0;
    for (int i = 7; i >= 0; i--) bit_io(b[i], s);
    if (!hold) begin
      bit_io(1'b1, s);
      ack = ~s;
    end
  endtask : wr_byte
  // master ack to go on, nack on the last byte
  task automatic rd_byte(input logic mack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
    bit_io(~mack, s);
  endtask : rd_byte
endmodule : i2c_master_model

// ==== dv/temp_sensor_i2c_slave_ctrl_tb.sv ====
// bench of the sensor slave: bus tasks and expected values
// assumes the master model and a pulled-up sda line
module temp_sensor_i2c_slave_ctrl_tb;
  import tsense_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int         CONV = 80;
  localparam int         TMO  = 2000;
  localparam int         RT [4] = '{400, 200, 160, 120};
  localparam logic [7:0] DEV = {ADDR_HI, 3'h2, 1'b0};
  logic        i_core_clk = 1'b0;
  logic        i_srst = 1'b1;
  logic        scl, m_sda, sda_o, sda_oe, act, done, ack;
  logic [11:0] adc = 12'h4c0;
  logic [11:0] temp;
  logic [15:0] v;
  flags_t      flg;
  cfg_t        cfg;
  int          err_total = 0;
  int          num_checks = 0;
  int          n, a;
  // wired sda: low if either party pulls
  wire sda = m_sda & ~(sda_oe & ~sda_o);
  always #2 i_core_clk = ~i_core_clk;
  i2c_master_model m_u (.i_core_clk(i_core_clk), .i_sda(sda),
    .o_scl(scl), .o_sda_drv(m_sda));
  temp_sensor_i2c_slave_ctrl #(.ADDR_LOW(3'h2), .CONV_CYC(CONV),
    .TIMEOUT_CYC(TMO), .RATE0_CYC(RT[0]), .RATE1_CYC(RT[1]),
    .RATE2_CYC(RT[2]), .RATE3_CYC(RT[3])) dut_u (
    .i_core_clk(i_core_clk), .i_srst(i_srst), .i_scl(scl),
    .i_sda(sda), .o_sda_o(sda_o), .o_sda_oe(sda_oe),
    .i_adc_result(adc), .o_conv_active(act), .o_conv_done(done),
    .o_temp(temp), .o_flags(flg), .o_cfg(cfg));
  // ==================================================================
  // checks and bus tasks
  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : give_verdict
  task automatic chk(string nm, logic [15:0] s, logic [15:0] e);
    num_checks++;
    if (s !== e) begin
      err_total++;
      $display("CHECK FAILED %s exp %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic tck(input int c);
    repeat (c) @(posedge i_core_clk);
    #1;
  endtask : tck
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    m_u.start();
    m_u.wr_byte(DEV, 1'b0, ack);
    chk("ack_a", ack, 1);
    m_u.wr_byte(p, 1'b0, ack);
    chk("ack_p", ack, 1);
    m_u.wr_byte(d, 1'b0, ack);
    chk("ack_d", ack, 1);
    m_u.stop();
  endtask : wr
  task automatic rd(input logic sp, input logic [7:0] p);
    if (sp) begin
      m_u.start();
      m_u.wr_byte(DEV, 1'b0, ack);
      m_u.wr_byte(p, 1'b0, ack);
    end
    m_u.start();
    m_u.wr_byte(DEV | 8'h01, 1'b0, ack);
    chk("ack_r", ack, 1);
    m_u.rd_byte(1'b1, v[15:8]);
    m_u.rd_byte(1'b0, v[7:0]);
    m_u.stop();
  endtask : rd
  // cycles to the next done pulse, and active cycles among them
  task automatic wdone();
    n = 0;
    a = 0;
    do begin
      tck(1);
      n++;
      if (act === 1'b1) a++;
      if (n > 1000) begin
        err_total++;
        give_verdict();
      end
    end while (done !== 1'b1);
  endtask : wdone
  // ==================================================================
  // main sequence
  initial begin
    tck(3);
    chk("cfg_rst", cfg, CFG_RST);
    chk("flg_rst", flg, 2'b00);
    chk("sda_o", sda_o, 0);
    i_srst = 1'b0;
    tck(1);
    chk("act_rst", act, 1);
    rd(1'b1, {5'h00, PTR_CFG});
    chk("cfg_rd", v, 16'h8000);
    m_u.start();
    m_u.wr_byte(8'he0, 1'b0, ack);
    chk("foreign", ack, 0);
    m_u.wr_byte(DEV, 1'b0, ack);
    m_u.start();
    m_u.wr_byte(DEV, 1'b0, ack);
    m_u.wr_byte(8'h08, 1'b0, ack);
    chk("bad_ptr", ack, 0);
    m_u.stop();
    for (int r = 0; r < 4; r++) begin
      wr(8'h01, {2'b10, r[1:0], 4'h0});
      wdone();
      wdone();
      chk("period", n, RT[r]);
      chk("conv", a, CONV);
    end
    adc = 12'h600;
    wdone();
    tck(1);
    chk("temp", temp, 12'h600);
    chk("over", flg, 2'b10);
    adc = 12'h300;
    wdone();
    tck(1);
    chk("under", flg, 2'b01);
    wr(8'h01, 8'hb8);
    adc = 12'h600;
    wdone();
    tck(1);
    chk("latch", flg, 2'b11);
    wr(8'h01, 8'h38);
    tck(200);
    chk("shut", act, 0);
    chk("held", flg, 2'b11);
    rd(1'b1, 8'h01);
    chk("rd_clr", flg, 2'b00);
    wr(8'h01, 8'h78);
    chk("os_act", act, 1);
    chk("os_md", {cfg.op_mode_hi, cfg.op_mode_lo}, 2'b01);
    wdone();
    tck(1);
    chk("os_end", {cfg.op_mode_hi, cfg.op_mode_lo}, 2'b00);
    chk("os_flg", flg, 2'b10);
    adc = 12'h4c0;
    wr(8'h01, 8'h78);
    wdone();
    tck(1);
    chk("in_rng", flg, 2'b00);
    wr({5'h00, PTR_THIGH}, 8'h5a);
    rd(1'b1, {5'h00, PTR_THIGH});
    chk("lim", v, 16'h5a00);
    rd(1'b0, 8'h00);
    chk("keep", v, 16'h5a00);
    m_u.start();
    m_u.wr_byte(DEV, 1'b1, ack);
    tck(3);
    chk("hold_ack", sda_oe, 1);
    tck(TMO + 20);
    chk("timeout", sda_oe, 0);
    m_u.start();
    m_u.wr_byte(GC_ADDR_BYTE, 1'b0, ack);
    chk("gc_ack", ack, 1);
    m_u.wr_byte(GC_RESET_CMD, 1'b0, ack);
    m_u.stop();
    chk("gc_cfg", cfg, CFG_RST);
    chk("gc_act", act, 1);
    rd(1'b1, {5'h00, PTR_THIGH});
    chk("gc_lim", v, {TLIM_HIGH_RST, 4'h0});
    give_verdict();
  end
endmodule : temp_sensor_i2c_slave_ctrl_tb

// ==== rtl/conv_seq.sv ====
// conversion sequencer: shutdown, one-shot and paced continuous modes
// assumes reset pulses also on general-call reset from the bus side
module conv_seq
  import tsense_pkg::*;
#(
  parameter int unsigned CONV_CYC  = CONV_CYC_DEF,
  parameter int unsigned RATE0_CYC = RATE0_CYC_DEF,
  parameter int unsigned RATE1_CYC = RATE1_CYC_DEF,
  parameter int unsigned RATE2_CYC = RATE2_CYC_DEF,
  parameter int unsigned RATE3_CYC = RATE3_CYC_DEF
) (
  input  wire logic i_core_clk,
  input  wire logic i_srst,
  input  cfg_t      i_cfg,
  output logic      o_busy,
  output logic      o_done
);

  seq_st_t     st_q;
  logic [31:0] cnt_q;
  logic [31:0] busy_len_q;
  logic [1:0]  rate;
  logic [1:0]  mode;

  assign rate = {i_cfg.rate_sel_hi, i_cfg.rate_sel_lo};
  assign mode = {i_cfg.op_mode_hi, i_cfg.op_mode_lo};

  // idle time after a conversion for the chosen rate
  function automatic logic [31:0] wait_len(logic [1:0] r);
    int unsigned p;
    case (r)
      2'b00:   p = RATE0_CYC;
      2'b01:   p = RATE1_CYC;
      2'b10:   p = RATE2_CYC;
      default: p = RATE3_CYC;
    endcase
    wait_len = (p > CONV_CYC) ? 32'(p - CONV_CYC) : 32'h1;
  endfunction : wait_len

  // ==================================================================
  // state machine
  assign o_busy = (st_q == SEQ_CONV);
  assign o_done = (st_q == SEQ_CONV) && (cnt_q == 32'(CONV_CYC - 1));

  // converts at once after reset, then sleeps or paces
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      st_q  <= SEQ_CONV;
      cnt_q <= '0;
    end else begin
      case (st_q)
        SEQ_CONV: begin
          if (o_done) begin
            cnt_q <= '0;
            st_q  <= i_cfg.op_mode_hi ? SEQ_WAIT : SEQ_IDLE;
          end else begin
            cnt_q <= cnt_q + 32'h1;
          end
        end
        SEQ_WAIT: begin
          if (!i_cfg.op_mode_hi) begin
            cnt_q <= '0;
            st_q  <= SEQ_IDLE;
          end else if (cnt_q >= wait_len(rate) - 32'h1) begin
            cnt_q <= '0;
            st_q  <= SEQ_CONV;
          end else begin
            cnt_q <= cnt_q + 32'h1;
          end
        end
        SEQ_IDLE: begin
          cnt_q <= '0;
          if (mode != MODE_SHUT) begin
            st_q <= SEQ_CONV;
          end
        end
        default: begin
          cnt_q <= '0;
          st_q  <= SEQ_IDLE;
        end
      endcase
    end
  end

  // ==================================================================
  // checks
  always_ff @(posedge i_core_clk) begin
    if (i_srst || !o_busy) begin
      busy_len_q <= '0;
    end else begin
      busy_len_q <= busy_len_q + 32'h1;
    end
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_srst);

  a_conv_length: assert property (
    o_done |-> busy_len_q == 32'(CONV_CYC - 1))
    else $error("conversion length wrong");
  a_shutdown_idle: assert property (
    (st_q == SEQ_IDLE && mode == MODE_SHUT) |=> !o_busy)
    else $error("converter active in shutdown");
  a_cont_pacing: assert property (
    (o_done && i_cfg.op_mode_hi) |=> st_q == SEQ_WAIT)
    else $error("no pause after conversion");
  c_conv_done: cover property (o_done);

endmodule : conv_seq

// ==== rtl/temp_sensor_i2c_slave_ctrl.sv ====
// two-wire slave, register file and limit flags of the temperature sensor
// assumes scl/sda are async pins; adc result is stable at conversion end
// ==================================================================
// What this block does
// - latch mode holds limit flags until read or an in-range result
// - read command in latch mode (not in a cycle where a conversion ends) or in-range result clears flags
// - reset clears latch bit and both flags
// - one conversion takes 13 ms
// - rate field picks 0.25, 1, 4, 8 Hz
// - periodic: convert, power down, wait rest of rate period
// - reset starts a conversion immediately
// - mode 00: finish conversion, then shut down
// - mode 01: single conversion, then reads 00
// - upper mode bit set: continuous paced conversions
// - sda falling with scl high is start
// - own address or general call acked on ninth clock, else released
// - bytes msb first, eight clocks plus ack
// - scl from 1 kHz up to 3.4 MHz
// - first byte: seven-bit address plus direction
// - address is 1110 plus variant bits
// - byte after address is pointer, then data
// - pointer kept across transactions until rewritten
// - device acks address, pointer and data bytes
// - scl never driven; sda only open-drain
// - general call then 06 resets registers, pointer, flags and sequencer; bus engine state is not reset
// - pointer upper five bits zero, low three select
// - scl low 30 ms resets the interface
module temp_sensor_i2c_slave_ctrl
  import tsense_pkg::*;
#(
  parameter logic [2:0]  ADDR_LOW    = 3'h0,
  parameter int unsigned CONV_CYC    = CONV_CYC_DEF,
  parameter int unsigned TIMEOUT_CYC = TIMEOUT_CYC_DEF,
  parameter int unsigned RATE0_CYC   = RATE0_CYC_DEF,
  parameter int unsigned RATE1_CYC   = RATE1_CYC_DEF,
  parameter int unsigned RATE2_CYC   = RATE2_CYC_DEF,
  parameter int unsigned RATE3_CYC   = RATE3_CYC_DEF
) (
  input  wire logic        i_core_clk,
  input  wire logic        i_srst,
  input  wire logic        i_scl,
  input  wire logic        i_sda,
  output logic             o_sda_o,
  output logic             o_sda_oe,
  input  wire logic [11:0] i_adc_result,
  output logic             o_conv_active,
  output logic             o_conv_done,
  output logic [11:0]      o_temp,
  output flags_t           o_flags,
  output cfg_t             o_cfg
);

  logic [1:0]  scl_sync_q;
  logic [1:0]  sda_sync_q;
  logic        scl_q;
  logic        sda_q;
  logic        scl_s;
  logic        sda_s;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_det;
  logic        stop_det;
  bus_st_t     state_q;
  logic [3:0]  bit_cnt_q;
  logic        in_ack_q;
  logic [7:0]  shreg_q;
  logic [7:0]  tx_q;
  logic        sda_oe_q;
  logic        byte_sel_q;
  logic [2:0]  ptr_q;
  logic        wr_stb_q;
  logic        wr_lo_q;
  logic [7:0]  wr_data_q;
  logic        rd_evt_q;
  logic        gc_rst_q;
  logic [31:0] to_cnt_q;
  logic        to_hit;
  logic        soft_rst;
  logic [6:0]  own_addr;
  logic [7:0]  rd_byte;
  cfg_t        cfg_q;
  flags_t      flags_q;
  logic [11:0] temp_q;
  logic [11:0] thigh_q;
  logic [11:0] tlow_q;
  logic        seq_done;
  logic        res_over;
  logic        res_under;

  assign own_addr = {ADDR_HI, ADDR_LOW};
  assign soft_rst = i_srst || gc_rst_q;

  // ==================================================================
  // pin synchronisers and edge detection
  // core clock oversamples scl well past its top rate
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      scl_q      <= 1'b1;
      sda_q      <= 1'b1;
    end else begin
      scl_sync_q <= {scl_sync_q[0], i_scl};
      sda_sync_q <= {sda_sync_q[0], i_sda};
      scl_q      <= scl_sync_q[1];
      sda_q      <= sda_sync_q[1];
    end
  end

  // scl is only ever sampled, never driven
  assign scl_s     = scl_sync_q[1];
  assign sda_s     = sda_sync_q[1];
  assign scl_rise  = scl_s && !scl_q;
  assign scl_fall  = !scl_s && scl_q;
  assign start_det = scl_s && scl_q && sda_q && !sda_s;
  assign stop_det  = scl_s && scl_q && !sda_q && sda_s;

  // ==================================================================
  // stuck-low clock timeout
  always_ff @(posedge i_core_clk) begin
    if (i_srst || scl_s || to_hit) begin
      to_cnt_q <= '0;
    end else begin
      to_cnt_q <= to_cnt_q + 32'h1;
    end
  end
  assign to_hit = (to_cnt_q == 32'(TIMEOUT_CYC - 1));

  // ==================================================================
  // read data selection
  always_comb begin
    case (ptr_q)
      PTR_TEMP:  rd_byte = word_byte(temp_q, byte_sel_q);
      PTR_CFG:   rd_byte = byte_sel_q ? 8'h00 : cfg_byte(cfg_q, flags_q);
      PTR_TLOW:  rd_byte = word_byte(tlow_q, byte_sel_q);
      PTR_THIGH: rd_byte = word_byte(thigh_q, byte_sel_q);
      default:   rd_byte = 8'h00;
    endcase
  end

  // ==================================================================
  // bus protocol engine
  always_ff @(posedge i_core_clk) begin
    wr_stb_q <= 1'b0;
    rd_evt_q <= 1'b0;
    gc_rst_q <= 1'b0;
    if (i_srst || to_hit) begin
      state_q   <= ST_IDLE;
      bit_cnt_q <= '0;
      in_ack_q  <= 1'b0;
      sda_oe_q  <= 1'b0;
    end else if (start_det) begin
      state_q   <= ST_ADDR;
      bit_cnt_q <= '0;
      in_ack_q  <= 1'b0;
      sda_oe_q  <= 1'b0;
    end else if (stop_det) begin
      state_q  <= ST_IDLE;
      sda_oe_q <= 1'b0;
    end else if (state_q != ST_IDLE) begin
      if (scl_rise) begin
        if (bit_cnt_q < BITS_PER_BYTE) begin
          shreg_q   <= {shreg_q[6:0], sda_s};
          bit_cnt_q <= bit_cnt_q + 4'h1;
        end else if (state_q == ST_RD && sda_s) begin
          state_q <= ST_IDLE;
        end
      end else if (scl_fall) begin
        if (bit_cnt_q != BITS_PER_BYTE) begin
          if (state_q == ST_RD) begin
            sda_oe_q <= ~tx_q[3'(BIT_MSB - bit_cnt_q)];
          end
        end else if (!in_ack_q) begin
          in_ack_q <= 1'b1;
          sda_oe_q <= 1'b0;
          case (state_q)
            ST_ADDR: begin
              if (shreg_q[7:1] == own_addr) begin
                sda_oe_q   <= 1'b1;
                byte_sel_q <= 1'b0;
                if (shreg_q[0]) begin
                  state_q  <= ST_RD;
                  rd_evt_q <= 1'b1;
                end else begin
                  state_q <= ST_PTR;
                end
              end else if (shreg_q == GC_ADDR_BYTE) begin
                sda_oe_q <= 1'b1;
                state_q  <= ST_GC;
              end else begin
                state_q <= ST_IDLE;
              end
            end
            ST_PTR: begin
              if (shreg_q[7:3] == PTR_HI_ZERO) begin
                sda_oe_q   <= 1'b1;
                ptr_q      <= shreg_q[2:0];
                byte_sel_q <= 1'b0;
                state_q    <= ST_WR;
              end else begin
                state_q <= ST_IDLE;
              end
            end
            ST_WR: begin
              sda_oe_q   <= 1'b1;
              wr_stb_q   <= 1'b1;
              wr_lo_q    <= byte_sel_q;
              wr_data_q  <= shreg_q;
              byte_sel_q <= ~byte_sel_q;
            end
            ST_GC: begin
              sda_oe_q <= 1'b1;
              if (shreg_q == GC_RESET_CMD) begin
                gc_rst_q <= 1'b1;
              end
            end
            ST_RD: begin
              byte_sel_q <= ~byte_sel_q;
            end
            default: begin
              state_q <= ST_IDLE;
            end
          endcase
        end else begin
          in_ack_q  <= 1'b0;
          bit_cnt_q <= '0;
          sda_oe_q  <= 1'b0;
          if (state_q == ST_RD) begin
            tx_q     <= rd_byte;
            sda_oe_q <= ~rd_byte[7];
          end
        end
      end
    end
    // pointer survives transactions; only resets clear it
    if (soft_rst) begin
      ptr_q <= PTR_TEMP;
    end
  end

  // sda is only ever pulled low
  assign o_sda_o  = 1'b0;
  assign o_sda_oe = sda_oe_q;

  // ==================================================================
  // configuration and limit registers
  always_ff @(posedge i_core_clk) begin
    if (soft_rst) begin
      cfg_q   <= CFG_RST;
      thigh_q <= TLIM_HIGH_RST;
      tlow_q  <= TLIM_LOW_RST;
    end else begin
      if (seq_done && {cfg_q.op_mode_hi, cfg_q.op_mode_lo} == MODE_ONESHOT)
      begin
        {cfg_q.op_mode_hi, cfg_q.op_mode_lo} <= MODE_SHUT;
      end
      if (wr_stb_q) begin
        case (ptr_q)
          PTR_CFG: begin
            if (!wr_lo_q) begin
              cfg_q <= cfg_t'(wr_data_q[7:3]);
            end
          end
          PTR_TLOW: begin
            if (wr_lo_q) tlow_q[3:0] <= wr_data_q[7:4];
            else tlow_q[11:4] <= wr_data_q;
          end
          PTR_THIGH: begin
            if (wr_lo_q) thigh_q[3:0] <= wr_data_q[7:4];
            else thigh_q[11:4] <= wr_data_q;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ==================================================================
  // conversion result and limit flags
  assign res_over  = $signed(i_adc_result) > $signed(thigh_q);
  assign res_under = $signed(i_adc_result) < $signed(tlow_q);

  always_ff @(posedge i_core_clk) begin
    if (soft_rst) begin
      temp_q  <= TEMP_RST;
      flags_q <= '0;
    end else if (seq_done) begin
      temp_q <= i_adc_result;
      if (!cfg_q.latch_mode_bit || (!res_over && !res_under)) begin
        flags_q <= '{res_over, res_under};
      end else begin
        flags_q <= flags_q | flags_t'({res_over, res_under});
      end
    end else if (rd_evt_q && cfg_q.latch_mode_bit) begin
      flags_q <= '0;
    end
  end

  // ==================================================================
  // conversion sequencer
  conv_seq #(
    .CONV_CYC  (CONV_CYC),
    .RATE0_CYC (RATE0_CYC),
    .RATE1_CYC (RATE1_CYC),
    .RATE2_CYC (RATE2_CYC),
    .RATE3_CYC (RATE3_CYC)
  ) u_seq (
    .i_core_clk (i_core_clk),
    .i_srst     (soft_rst),
    .i_cfg      (cfg_q),
    .o_busy     (o_conv_active),
    .o_done     (seq_done)
  );

  assign o_conv_done = seq_done;
  assign o_temp      = temp_q;
  assign o_flags     = flags_q;
  assign o_cfg       = cfg_q;

  // ==================================================================
  // checks
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_srst);

  a_start_addr: assert property (
    (start_det && !to_hit) |=> state_q == ST_ADDR && !o_sda_oe)
    else $error("start not followed by address phase");
  a_addr_ack: assert property (
    (state_q == ST_ADDR && scl_fall && bit_cnt_q == BITS_PER_BYTE
     && !in_ack_q && shreg_q[7:1] == own_addr && !to_hit)
    |=> o_sda_oe ##1 (o_sda_oe || scl_fall || to_hit))
    else $error("own address not acknowledged");
  a_addr_nack: assert property (
    (state_q == ST_ADDR && scl_fall && bit_cnt_q == BITS_PER_BYTE
     && !in_ack_q && shreg_q[7:1] != own_addr && shreg_q != GC_ADDR_BYTE)
    |=> !o_sda_oe && state_q == ST_IDLE)
    else $error("foreign address acknowledged");
  a_ptr_hold: assert property (
    (!(state_q == ST_PTR && scl_fall) && !soft_rst) |=> $stable(ptr_q))
    else $error("pointer changed without pointer write");
  a_reset_clear: assert property (
    gc_rst_q |=> flags_q == '0 && !cfg_q.latch_mode_bit)
    else $error("reset left flags or latch bit set");
  a_oneshot_back: assert property (
    (seq_done && {cfg_q.op_mode_hi, cfg_q.op_mode_lo} == MODE_ONESHOT
     && !wr_stb_q && !soft_rst)
    |=> {cfg_q.op_mode_hi, cfg_q.op_mode_lo} == MODE_SHUT ##1 !o_conv_active)
    else $error("one-shot did not return to shutdown");
  a_latch_read: assert property (
    (rd_evt_q && cfg_q.latch_mode_bit && !seq_done && !soft_rst)
    |=> flags_q == '0)
    else $error("latched flags survived a read");
  a_timeout_rel: assert property (
    to_hit |=> state_q == ST_IDLE && !o_sda_oe)
    else $error("timeout did not release the bus");
  a_gc_reset: assert property (
    (state_q == ST_GC && scl_fall && bit_cnt_q == BITS_PER_BYTE
     && !in_ack_q && shreg_q == GC_RESET_CMD)
    |=> gc_rst_q ##1 (cfg_q == CFG_RST && o_conv_active))
    else $error("general call reset not applied");
  c_read_xfer: cover property (rd_evt_q);
  c_gc_reset: cover property (gc_rst_q);
  c_write_cfg: cover property (wr_stb_q && ptr_q == PTR_CFG);
  c_timeout: cover property (to_hit);

endmodule : temp_sensor_i2c_slave_ctrl

// ==== rtl/tsense_pkg.sv ====
// shared constants, types and helpers of the temperature sensor slave
// assumes a 250 MHz core clock; counts derive from that rate
package tsense_pkg;

  // ==================================================================
  // timing
  localparam int unsigned CLK_MHZ         = 250;
  localparam int unsigned CONV_TIME_US    = 13000;
  localparam int unsigned TIMEOUT_MS      = 30;
  localparam int unsigned RATE0_MS        = 4000;  // 0.25 Hz
  localparam int unsigned RATE1_MS        = 1000;  // 1 Hz
  localparam int unsigned RATE2_MS        = 250;   // 4 Hz
  localparam int unsigned RATE3_MS        = 125;   // 8 Hz
  localparam int unsigned US_PER_MS       = 1000;
  localparam int unsigned CONV_CYC_DEF    = CONV_TIME_US * CLK_MHZ;
  localparam int unsigned TIMEOUT_CYC_DEF = TIMEOUT_MS * US_PER_MS * CLK_MHZ;
  localparam int unsigned RATE0_CYC_DEF   = RATE0_MS * US_PER_MS * CLK_MHZ;
  localparam int unsigned RATE1_CYC_DEF   = RATE1_MS * US_PER_MS * CLK_MHZ;
  localparam int unsigned RATE2_CYC_DEF   = RATE2_MS * US_PER_MS * CLK_MHZ;
  localparam int unsigned RATE3_CYC_DEF   = RATE3_MS * US_PER_MS * CLK_MHZ;

  // ==================================================================
  // bus framing and addresses
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] BIT_MSB       = 4'h7;
  localparam logic [3:0] ADDR_HI       = 4'he;
  localparam logic [7:0] GC_ADDR_BYTE  = 8'h00;
  localparam logic [7:0] GC_RESET_CMD  = 8'h06;
  localparam logic [4:0] PTR_HI_ZERO   = 5'h00;

  // ==================================================================
  // register pointers and reset values
  localparam logic [2:0]  PTR_TEMP      = 3'h0;
  localparam logic [2:0]  PTR_CFG       = 3'h1;
  localparam logic [2:0]  PTR_TLOW      = 3'h2;
  localparam logic [2:0]  PTR_THIGH     = 3'h3;
  localparam logic [11:0] TEMP_RST      = 12'h000;
  localparam logic [11:0] TLIM_HIGH_RST = 12'h500;
  localparam logic [11:0] TLIM_LOW_RST  = 12'h4b0;

  // ==================================================================
  // modes and carriers
  localparam logic [1:0] MODE_SHUT    = 2'b00;
  localparam logic [1:0] MODE_ONESHOT = 2'b01;
  localparam logic [1:0] MODE_CONT    = 2'b10;
  localparam logic [1:0] RATE_RST     = 2'b00;

  typedef struct packed {
    logic op_mode_hi;
    logic op_mode_lo;
    logic rate_sel_hi;
    logic rate_sel_lo;
    logic latch_mode_bit;
  } cfg_t;

  typedef struct packed {
    logic over_limit_flag;
    logic under_limit_flag;
  } flags_t;

  localparam cfg_t CFG_RST = '{MODE_CONT[1], MODE_CONT[0],
                               RATE_RST[1], RATE_RST[0], 1'b0};

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_PTR  = 3'b010,
    ST_WR   = 3'b011,
    ST_RD   = 3'b100,
    ST_GC   = 3'b101
  } bus_st_t;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_CONV = 2'b01,
    SEQ_WAIT = 2'b10
  } seq_st_t;

  // config byte: mode, rate, latch, flags, one zero bit
  function automatic logic [7:0] cfg_byte(cfg_t c, flags_t f);
    cfg_byte = {c, f, 1'b0};
  endfunction : cfg_byte

  // left-justified 12-bit word, high byte first
  function automatic logic [7:0] word_byte(logic [11:0] w, logic lo);
    logic [15:0] full;
    full = {w, 4'h0};
    word_byte = lo ? full[7:0] : full[15:8];
  endfunction : word_byte

endpackage : tsense_pkg
